/* src/bit_xfer_exec.v */
// Execution unit for bit, shift, flag, transfer and control operations with its own register file.
`timescale 1ns/1ps
`default_nettype none
`include "bit_xfer_exec_regs.vh"

module bit_xfer_exec (
	input wire ref_clk,
	input wire reset,
	input wire [5:0] bus_addr,
	input wire [7:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	output reg [7:0] bus_rdata,
	output wire busy,
	output wire op_done,
	output wire irq_enable,
	output reg [15:0] dmem_addr,
	output reg [7:0] dmem_wdata,
	output reg dmem_wr,
	output reg dmem_rd,
	input wire [7:0] dmem_rdata,
	output reg [15:0] pmem_addr,
	output reg pmem_rd,
	input wire [7:0] pmem_rdata,
	output reg [4:0] io_addr,
	output reg [2:0] io_bit_num,
	output reg io_bit_set,
	output reg io_bit_clr,
	output reg sleep_req,
	output reg wdt_restart,
	output reg break_req
);

	// ----------------------------------------------------------------
	// States and storage
	// ----------------------------------------------------------------
	localparam [3:0] S_IDLE = 4'b0001;
	localparam [3:0] S_EXEC = 4'b0010;
	localparam [3:0] S_WAIT = 4'b0100;
	localparam [3:0] S_LAST = 4'b1000;

	reg [7:0] gpr [0:31];
	reg [7:0] flags_r;
	reg [4:0] dst_r;
	reg [4:0] src_r;
	reg [7:0] imm_r;
	reg [7:0] mode_r;
	reg [15:0] kaddr_r;
	reg [15:0] sp_r;
	reg [4:0] op_r;
	reg [3:0] state_r;
	reg reject_r;
	integer i;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Pointer pairs sit at the top of the register file.
	function [4:0] ptr_base;
		input [1:0] sel;
		begin
			case (sel)
				`PTR_X: ptr_base = 5'd26;
				`PTR_Y: ptr_base = 5'd28;
				default: ptr_base = 5'd30;
			endcase
		end
	endfunction

	// Returns {carry_out, result} for the shift and rotate group.
	function [8:0] shift_calc;
		input [4:0] op;
		input [7:0] val;
		input cin;
		begin
			case (op)
				`OP_SHL: shift_calc = {val[7], val[6:0], 1'b0};
				`OP_SHR: shift_calc = {val[0], 1'b0, val[7:1]};
				`OP_RLC: shift_calc = {val[7], val[6:0], cin};
				`OP_RRC: shift_calc = {val[0], cin, val[7:1]};
				`OP_SAR: shift_calc = {val[0], val[7], val[7:1]};
				default: shift_calc = {cin, val};
			endcase
		end
	endfunction

	// Operations whose whole effect lands in the first execute cycle.
	function is_single;
		input [4:0] op;
		begin
			case (op)
				`OP_IO_SET, `OP_IO_CLR, `OP_LOAD, `OP_STORE, `OP_DLOAD, `OP_DSTORE,
				`OP_PREAD, `OP_PUSH, `OP_POP: is_single = 1'b0;
				default: is_single = 1'b1;
			endcase
		end
	endfunction

	function [15:0] pair;
		input [7:0] hi;
		input [7:0] lo;
		begin
			pair = {hi, lo};
		end
	endfunction

	// ----------------------------------------------------------------
	// Command acceptance
	// ----------------------------------------------------------------
	wire cmd_wr = bus_wr && (bus_addr == `ADDR_CMD) && state_r[0];
	wire [4:0] cmd_op = bus_wdata[4:0];
	wire [4:0] base = ptr_base(mode_r[`MODE_PTR]);
	wire [4:0] base_hi = base + 5'd1;
	wire [15:0] ptr_val = pair(gpr[base_hi], gpr[base]);
	wire [1:0] am = mode_r[`MODE_AM];
	wire [15:0] z_val = pair(gpr[31], gpr[30]);

	reg [15:0] acc_addr;
	reg acc_reject;
	reg acc_dmem;
	always @* begin
		acc_addr = ptr_val;
		acc_reject = 1'b0;
		acc_dmem = 1'b0;
		case (cmd_op)
			`OP_LOAD, `OP_STORE: begin
				acc_dmem = 1'b1;
				case (am)
					`AM_PREDEC: acc_addr = ptr_val - 16'h0001;
					`AM_DISP: acc_addr = ptr_val + {10'h000, imm_r[5:0]};
					default: acc_addr = ptr_val;
				endcase
				// Displacement is only defined on Y and Z.
				if (am == `AM_DISP && mode_r[`MODE_PTR] == `PTR_X) begin
					acc_reject = 1'b1;
				end
				if (mode_r[`MODE_PTR] == 2'h3) begin
					acc_reject = 1'b1;
				end
			end
			`OP_DLOAD, `OP_DSTORE: begin
				acc_dmem = 1'b1;
				acc_addr = kaddr_r;
			end
			`OP_PUSH: begin
				acc_dmem = 1'b1;
				acc_addr = sp_r;
			end
			`OP_POP: begin
				acc_dmem = 1'b1;
				acc_addr = sp_r + 16'h0001;
			end
			`OP_IO_SET, `OP_IO_CLR: begin
				// Addresses above the bit-reachable window are refused outright.
				acc_reject = (imm_r > `IO_BIT_TOP);
			end
			default: begin
				acc_reject = (cmd_op > `OP_BREAK);
			end
		endcase
	end

	wire acc_load = (cmd_op == `OP_LOAD) || (cmd_op == `OP_DLOAD) || (cmd_op == `OP_POP);

	// ----------------------------------------------------------------
	// Execute-cycle results
	// ----------------------------------------------------------------
	wire [8:0] sh = shift_calc(op_r, gpr[dst_r], flags_r[`FLAG_C]);
	wire [7:0] sh_res = sh[7:0];
	wire sh_n = sh_res[7];
	wire [4:0] dst_pair = {dst_r[4:1], 1'b0};
	wire [4:0] src_pair = {src_r[4:1], 1'b0};
	wire [2:0] bitsel = mode_r[`MODE_BIT];

	wire in_exec = state_r[1];
	wire in_wait = state_r[2];
	wire in_last = state_r[3];
	wire op_is_pread = (op_r == `OP_PREAD);
	wire op_is_load = (op_r == `OP_LOAD) || (op_r == `OP_DLOAD) || (op_r == `OP_POP);

	assign busy = ~state_r[0];
	// Marks the last cycle of the running operation.
	assign op_done = (in_exec && is_single(op_r)) || (in_wait && !op_is_pread) || in_last;
	assign irq_enable = flags_r[`FLAG_I];

	// ----------------------------------------------------------------
	// Sequencer and port strobes
	// ----------------------------------------------------------------
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_r <= S_IDLE;
			op_r <= `OP_NOP;
			reject_r <= 1'b0;
			dmem_addr <= 16'h0000;
			dmem_wdata <= 8'h00;
			dmem_wr <= 1'b0;
			dmem_rd <= 1'b0;
			pmem_addr <= 16'h0000;
			pmem_rd <= 1'b0;
			io_addr <= 5'h00;
			io_bit_num <= 3'h0;
			io_bit_set <= 1'b0;
			io_bit_clr <= 1'b0;
			sleep_req <= 1'b0;
			wdt_restart <= 1'b0;
			break_req <= 1'b0;
		end else begin
			dmem_wr <= 1'b0;
			dmem_rd <= 1'b0;
			pmem_rd <= 1'b0;
			io_bit_set <= 1'b0;
			io_bit_clr <= 1'b0;
			sleep_req <= 1'b0;
			wdt_restart <= 1'b0;
			break_req <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (cmd_wr) begin
						reject_r <= acc_reject;
						if (!acc_reject) begin
							op_r <= cmd_op;
							state_r <= S_EXEC;
							// Access strobes are set up here so they stand in the first execute cycle.
							if (acc_dmem) begin
								dmem_addr <= acc_addr;
								dmem_wdata <= gpr[src_r];
								dmem_rd <= acc_load;
								dmem_wr <= ~acc_load;
							end
							if (cmd_op == `OP_PREAD) begin
								pmem_addr <= z_val;
								pmem_rd <= 1'b1;
							end
							if (cmd_op == `OP_IO_SET || cmd_op == `OP_IO_CLR) begin
								io_addr <= imm_r[4:0];
								io_bit_num <= bitsel;
								// A single-bit strobe never rewrites neighbouring flag bits.
								io_bit_set <= (cmd_op == `OP_IO_SET);
								io_bit_clr <= (cmd_op == `OP_IO_CLR);
							end
							sleep_req <= (cmd_op == `OP_SLEEP);
							wdt_restart <= (cmd_op == `OP_WDOG);
							// Debug logic takes over after this strobe; the unit itself spends one cycle.
							break_req <= (cmd_op == `OP_BREAK);
						end
					end
				end
				S_EXEC: begin
					if (is_single(op_r)) begin
						state_r <= S_IDLE;
					end else begin
						state_r <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (op_is_pread) begin
						state_r <= S_LAST;
					end else begin
						state_r <= S_IDLE;
					end
				end
				S_LAST: begin
					state_r <= S_IDLE;
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Register file, flags and stack pointer
	// ----------------------------------------------------------------
	// Software writes come first so that a result of the running operation
	// in the same cycle takes precedence over them.
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			for (i = 0; i < 32; i = i + 1) begin
				gpr[i] <= 8'h00;
			end
			flags_r <= `FLAGS_RESET;
			dst_r <= 5'h00;
			src_r <= 5'h00;
			imm_r <= 8'h00;
			mode_r <= 8'h00;
			kaddr_r <= 16'h0000;
			sp_r <= `SP_RESET;
		end else begin
			if (bus_wr) begin
				if (bus_addr <= `ADDR_GPR_TOP) begin
					gpr[bus_addr[4:0]] <= bus_wdata;
				end
				case (bus_addr)
					`ADDR_FLAGS: flags_r <= bus_wdata;
					`ADDR_DST: dst_r <= bus_wdata[4:0];
					`ADDR_SRC: src_r <= bus_wdata[4:0];
					`ADDR_IMM: imm_r <= bus_wdata;
					`ADDR_MODE: mode_r <= bus_wdata;
					`ADDR_KLO: kaddr_r[7:0] <= bus_wdata;
					`ADDR_KHI: kaddr_r[15:8] <= bus_wdata;
					`ADDR_SPLO: sp_r[7:0] <= bus_wdata;
					`ADDR_SPHI: sp_r[15:8] <= bus_wdata;
					default: begin
					end
				endcase
			end
			if (in_exec) begin
				case (op_r)
					`OP_SHL, `OP_SHR, `OP_RLC, `OP_RRC, `OP_SAR: begin
						gpr[dst_r] <= sh_res;
						flags_r[`FLAG_C] <= sh[8];
						flags_r[`FLAG_Z] <= (sh_res == 8'h00);
						flags_r[`FLAG_N] <= sh_n;
						flags_r[`FLAG_V] <= sh_n ^ sh[8];
					end
					`OP_SWAP: gpr[dst_r] <= {gpr[dst_r][3:0], gpr[dst_r][7:4]};
					`OP_FSET: flags_r[bitsel] <= 1'b1;
					`OP_FCLR: flags_r[bitsel] <= 1'b0;
					`OP_B2T: flags_r[`FLAG_T] <= gpr[src_r][bitsel];
					`OP_T2B: gpr[dst_r][bitsel] <= flags_r[`FLAG_T];
					`OP_IEN: flags_r[`FLAG_I] <= 1'b1;
					`OP_IDIS: flags_r[`FLAG_I] <= 1'b0;
					`OP_COPY: gpr[dst_r] <= gpr[src_r];
					`OP_KLOAD: gpr[dst_r] <= imm_r;
					`OP_PCOPY: begin
						gpr[dst_pair] <= gpr[src_pair];
						gpr[dst_pair + 5'd1] <= gpr[src_pair + 5'd1];
					end
					`OP_LOAD, `OP_STORE: begin
						if (am == `AM_PREDEC) begin
							gpr[base] <= dmem_addr[7:0];
							gpr[base_hi] <= dmem_addr[15:8];
						end
						// A store may advance its pointer now: the write is already out.
						if (am == `AM_POSTINC && op_r == `OP_STORE) begin
							gpr[base] <= dmem_addr[7:0] + 8'h01;
							gpr[base_hi] <= dmem_addr[15:8] + {7'h00, (dmem_addr[7:0] == 8'hFF)};
						end
					end
					`OP_PUSH: sp_r <= sp_r - 16'h0001;
					`OP_POP: sp_r <= dmem_addr;
					default: begin
					end
				endcase
			end
			if (in_wait && op_is_load) begin
				// The pointer moves only after the data at its old value is taken.
				if (op_r == `OP_LOAD && am == `AM_POSTINC) begin
					gpr[base] <= dmem_addr[7:0] + 8'h01;
					gpr[base_hi] <= dmem_addr[15:8] + {7'h00, (dmem_addr[7:0] == 8'hFF)};
				end
				gpr[dst_r] <= dmem_rdata;
			end
			if (in_last) begin
				if (am == `AM_POSTINC) begin
					gpr[30] <= pmem_addr[7:0] + 8'h01;
					gpr[31] <= pmem_addr[15:8] + {7'h00, (pmem_addr[7:0] == 8'hFF)};
				end
				if (am == `AM_PLAIN) begin
					gpr[0] <= pmem_rdata;
				end else begin
					gpr[dst_r] <= pmem_rdata;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bus_rdata <= 8'h00;
		end else if (bus_rd) begin
			if (bus_addr <= `ADDR_GPR_TOP) begin
				bus_rdata <= gpr[bus_addr[4:0]];
			end else begin
				case (bus_addr)
					`ADDR_FLAGS: bus_rdata <= flags_r;
					`ADDR_DST: bus_rdata <= {3'h0, dst_r};
					`ADDR_SRC: bus_rdata <= {3'h0, src_r};
					`ADDR_IMM: bus_rdata <= imm_r;
					`ADDR_MODE: bus_rdata <= mode_r;
					`ADDR_KLO: bus_rdata <= kaddr_r[7:0];
					`ADDR_KHI: bus_rdata <= kaddr_r[15:8];
					`ADDR_SPLO: bus_rdata <= sp_r[7:0];
					`ADDR_SPHI: bus_rdata <= sp_r[15:8];
					`ADDR_CMD: bus_rdata <= {3'h0, op_r};
					`ADDR_STAT: bus_rdata <= {6'h00, reject_r, busy};
					default: bus_rdata <= 8'h00;
				endcase
			end
		end
	end

endmodule // bit_xfer_exec

`default_nettype wire

/* src/bit_xfer_exec_regs.vh */
// Register offsets, field positions, operation codes and reset values of the execution unit.
//
// How it works
// - I/O bit set and clear force one I/O bit, take 2 cycles, no flags.
// - I/O bit set and clear reach only I/O 0x00..0x1F and touch one bit.
// - Left shift moves bits up, bit 0 gets 0, updates Z C N V, 1 cycle.
// - Right shift moves bits down, bit 7 gets 0, updates Z C N V, 1 cycle.
// - Rotates pass carry into the end bit and the leaving bit into carry, 1 cycle.
// - Arithmetic right shift keeps bit 7, updates Z C N V in 1 cycle.
// - Nibble swap exchanges the two halves in 1 cycle, no flags.
// - Each status flag can be set or cleared by index in 1 cycle alone.
// - Bit store copies a register bit into T in 1 cycle.
// - Bit load copies T into a register bit in 1 cycle, no flags.
// - Global interrupt enable and disable set or clear I in 1 cycle.
// - Register copy and immediate load take 1 cycle, no flags.
// - Register pair copy moves two adjacent registers in 1 cycle, no flags.
// - Post-increment loads read at the pointer first, then add one, 2 cycles.
// - Pre-decrement loads and stores subtract one before the access, 2 cycles.
// - Displaced accesses use Y or Z plus displacement, pointer kept, 2 cycles.
// - Indirect stores write a register to data space in 2 cycles, no flags.
// - Direct load and store use the address in the instruction, 2 cycles.
// - Program memory read loads byte at Z into R0 or Rd, optional Z+, 3 cycles.
// - Push and pop move one register to or from the stack in 2 cycles.
// - Sleep and watchdog restart take 1 cycle and change no flag.
// - Break is for on-chip debug only and has no defined cycle count.
`ifndef BIT_XFER_EXEC_REGS_VH
`define BIT_XFER_EXEC_REGS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_GPR_TOP 6'h1F
`define ADDR_FLAGS 6'h20
`define ADDR_DST 6'h21
`define ADDR_SRC 6'h22
`define ADDR_IMM 6'h23
`define ADDR_MODE 6'h24
`define ADDR_KLO 6'h25
`define ADDR_KHI 6'h26
`define ADDR_SPLO 6'h27
`define ADDR_SPHI 6'h28
`define ADDR_CMD 6'h29
`define ADDR_STAT 6'h2A

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7
`define MODE_BIT 2:0
`define MODE_PTR 4:3
`define MODE_AM 6:5
`define STAT_BUSY 0
`define STAT_REJECT 1
`define PTR_X 2'h0
`define PTR_Y 2'h1
`define PTR_Z 2'h2
`define AM_PLAIN 2'h0
`define AM_POSTINC 2'h1
`define AM_PREDEC 2'h2
`define AM_DISP 2'h3
`define IO_BIT_TOP 8'h1F

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define OP_NOP 5'h00
`define OP_IO_SET 5'h01
`define OP_IO_CLR 5'h02
`define OP_SHL 5'h03
`define OP_SHR 5'h04
`define OP_RLC 5'h05
`define OP_RRC 5'h06
`define OP_SAR 5'h07
`define OP_SWAP 5'h08
`define OP_FSET 5'h09
`define OP_FCLR 5'h0A
`define OP_B2T 5'h0B
`define OP_T2B 5'h0C
`define OP_IEN 5'h0D
`define OP_IDIS 5'h0E
`define OP_COPY 5'h0F
`define OP_PCOPY 5'h10
`define OP_KLOAD 5'h11
`define OP_LOAD 5'h12
`define OP_STORE 5'h13
`define OP_DLOAD 5'h14
`define OP_DSTORE 5'h15
`define OP_PREAD 5'h16
`define OP_PUSH 5'h17
`define OP_POP 5'h18
`define OP_SLEEP 5'h19
`define OP_WDOG 5'h1A
`define OP_BREAK 5'h1B

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FLAGS_RESET 8'h00
`define SP_RESET 16'h0000

`endif

/* tb/bit_xfer_exec_props.sv */
// Concurrent checks on the ports of the bit and transfer execution unit.
`timescale 1ns/1ps
`default_nettype none
module bit_xfer_exec_props (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [5:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic busy,
	input wire logic op_done,
	input wire logic irq_enable,
	input wire logic dmem_rd,
	input wire logic dmem_wr,
	input wire logic [15:0] dmem_addr,
	input wire logic pmem_rd,
	input wire logic [4:0] io_addr,
	input wire logic io_bit_set,
	input wire logic io_bit_clr,
	input wire logic sleep_req,
	input wire logic wdt_restart,
	input wire logic break_req
);
	logic [7:0] imm_r;
	logic cmd_go;
	logic io_op;
	// A command is only taken while idle; a write during busy is dropped.
	assign cmd_go = bus_wr && bus_addr == 6'h29 && !busy;
	assign io_op = bus_wdata == 8'h01 || bus_wdata == 8'h02;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			imm_r <= 8'h00;
		else if (bus_wr && bus_addr == 6'h23)
			imm_r <= bus_wdata;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence one_cyc_s;
		(busy && op_done) ##1 !busy;
	endsequence
	sequence two_cyc_s;
		(busy && !op_done) ##1 one_cyc_s;
	endsequence
	io_bit_len_a: assert property (cmd_go && io_op && imm_r <= 8'h1F |=> two_cyc_s)
		else $error("io bit op length wrong");
	io_bit_target_a: assert property (cmd_go && io_op && imm_r <= 8'h1F |=> io_addr == imm_r[4:0]
		&& io_bit_set == ($past(bus_wdata) == 8'h01) && io_bit_clr == ($past(bus_wdata) == 8'h02))
		else $error("io bit op target wrong");
	io_bit_refuse_a: assert property (cmd_go && io_op && imm_r > 8'h1F |=> !busy && !io_bit_set && !io_bit_clr)
		else $error("io address above range executed");
	single_cycle_a: assert property (cmd_go && bus_wdata >= 8'h03 && bus_wdata <= 8'h11 |=> one_cyc_s)
		else $error("single cycle op length wrong");
	two_cycle_a: assert property (cmd_go && (bus_wdata == 8'h14 || bus_wdata == 8'h15
		|| bus_wdata == 8'h17 || bus_wdata == 8'h18) |=> two_cyc_s)
		else $error("two cycle op length wrong");
	prog_read_a: assert property (cmd_go && bus_wdata == 8'h16 |=> (pmem_rd && !op_done) ##1 two_cyc_s)
		else $error("program read length wrong");
	load_strobe_a: assert property (dmem_rd |-> busy && !op_done ##1 (op_done && !dmem_rd))
		else $error("load strobe timing wrong");
	store_hold_a: assert property (dmem_wr |=> op_done && !dmem_wr && $stable(dmem_addr))
		else $error("store strobe timing wrong");
	irq_flag_a: assert property (cmd_go && (bus_wdata == 8'h0D || bus_wdata == 8'h0E)
		|-> ##2 irq_enable == ($past(bus_wdata, 2) == 8'h0D))
		else $error("interrupt enable flag wrong");
	ctrl_pulse_a: assert property (sleep_req || wdt_restart || break_req |-> busy && op_done)
		else $error("control pulse outside single cycle");
endmodule // bit_xfer_exec_props
bind bit_xfer_exec bit_xfer_exec_props chk (.ref_clk, .reset, .bus_addr, .bus_wdata, .bus_wr, .busy, .op_done,
	.irq_enable, .dmem_rd, .dmem_wr, .dmem_addr, .pmem_rd, .io_addr, .io_bit_set, .io_bit_clr, .sleep_req,
	.wdt_restart, .break_req);
`default_nettype wire

/* tb/data_prog_mem.sv */
// Data space and program memory model on the far side of the execution unit.
`timescale 1ns/1ps
`default_nettype none
module data_prog_mem (
	input wire logic ref_clk,
	input wire logic [15:0] dmem_addr,
	input wire logic [7:0] dmem_wdata,
	input wire logic dmem_wr,
	input wire logic dmem_rd,
	output var logic [7:0] dmem_rdata,
	input wire logic [15:0] pmem_addr,
	input wire logic pmem_rd,
	output var logic [7:0] pmem_rdata
);
	logic [7:0] mem [0:511];
	logic pmem_wait_r = 1'b0;
	// Outside the valid slot the data toggles, so a sample one cycle late sees the inverted value.
	initial begin
		dmem_rdata = 8'h55;
		pmem_rdata = 8'h55;
	end
	always @(posedge ref_clk) begin
		if (dmem_wr)
			mem[dmem_addr[8:0]] <= dmem_wdata;
		dmem_rdata <= dmem_rd ? mem[dmem_addr[8:0]] : ~dmem_rdata;
		pmem_wait_r <= pmem_rd;
		pmem_rdata <= pmem_wait_r ? (pmem_addr[7:0] ^ pmem_addr[15:8] ^ 8'h3C) : ~pmem_rdata;
	end
endmodule // data_prog_mem
`default_nettype wire

/* tb/cpu_bit_transfer_instr_exec_test.sv */
// Self-checking testbench of the bit and transfer execution unit.
`timescale 1ns/1ps
`default_nettype none
`include "bit_xfer_exec_regs.vh"
module cpu_bit_transfer_instr_exec_test;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [5:0] bus_addr = 6'h00;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	wire [7:0] bus_rdata, dmem_wdata, dmem_rdata, pmem_rdata;
	wire [15:0] dmem_addr, pmem_addr;
	wire [4:0] io_addr;
	wire [2:0] io_bit_num;
	wire busy, op_done, irq_enable, dmem_wr, dmem_rd, pmem_rd, io_bit_set, io_bit_clr, sleep_req, wdt_restart;
	wire break_req;
	integer fail_count = 0;
	integer tests_run = 0;
	integer cyc = 0;
	integer io_cnt = 0;
	integer ctl_cnt = 0;
	logic [9:0] io_seen = 10'h000;
	always #2.5 ref_clk = ~ref_clk;
	bit_xfer_exec dut (.ref_clk(ref_clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .busy(busy), .op_done(op_done),
		.irq_enable(irq_enable), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_wr(dmem_wr),
		.dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
		.pmem_rdata(pmem_rdata), .io_addr(io_addr), .io_bit_num(io_bit_num), .io_bit_set(io_bit_set),
		.io_bit_clr(io_bit_clr), .sleep_req(sleep_req), .wdt_restart(wdt_restart), .break_req(break_req));
	data_prog_mem far_end (.ref_clk(ref_clk), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_wr(dmem_wr),
		.dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
		.pmem_rdata(pmem_rdata));
	// ----------------------------------------------------------------
	// Pulse monitors and hang guard
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (io_bit_set || io_bit_clr) begin
			io_cnt = io_cnt + 1;
			io_seen = {io_bit_set, io_bit_clr, io_bit_num, io_addr};
		end
		if (sleep_req || wdt_restart || break_req)
			ctl_cnt = ctl_cnt + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			final_report;
		end
	end
	// ----------------------------------------------------------------
	// Bus and check helpers
	// ----------------------------------------------------------------
	task automatic chk(input string name, input [15:0] exp, input [15:0] got);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input [5:0] a, input [7:0] d);
		@(posedge ref_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
	endtask
	task automatic rchk(input string name, input [5:0] a, input [7:0] exp);
		@(posedge ref_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		#1 chk(name, {8'h00, exp}, {8'h00, bus_rdata});
	endtask
	task automatic run(input [7:0] op);
		integer n;
		wr(`ADDR_CMD, op);
		n = 0;
		#1;
		while (busy === 1'b1 && n < 10) begin
			@(posedge ref_clk);
			#1;
			n = n + 1;
		end
		chk("op_finished", 16'h0000, {15'h0000, busy});
	endtask
	task automatic opnd(input [7:0] dst, input [7:0] src, input [7:0] mode);
		wr(`ADDR_DST, dst);
		wr(`ADDR_SRC, src);
		wr(`ADDR_MODE, mode);
	endtask
	task automatic pair(input [5:0] lo, input [15:0] v);
		wr(lo, v[7:0]);
		wr(lo + 6'h01, v[15:8]);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_shift;
		logic [7:0] v, r, s;
		logic c;
		for (int k = 0; k < 2; k++) begin
			for (int i = 3; i <= 8; i++) begin
				v = k ? 8'h80 : 8'h81;
				wr(6'h10, v);
				wr(6'h20, 8'h35);
				opnd(8'h10, 8'h10, 8'h00);
				run(i[7:0]);
				case (i)
					3: r = {v[6:0], 1'b0};
					4: r = {1'b0, v[7:1]};
					5: r = {v[6:0], 1'b1};
					6: r = {1'b1, v[7:1]};
					7: r = {v[7], v[7:1]};
					default: r = {v[3:0], v[7:4]};
				endcase
				c = (i == 3 || i == 5) ? v[7] : v[0];
				s = (i == 8) ? 8'h35 : {4'h3, r[7] ^ c, r[7], r == 8'h00, c};
				rchk("shift_result", 6'h10, r);
				rchk("shift_flags", 6'h20, s);
			end
		end
	endtask
	task automatic t_flags;
		for (int i = 0; i < 8; i++) begin
			wr(6'h20, 8'h00);
			wr(`ADDR_MODE, i[7:0]);
			run(8'h09);
			rchk("flag_set", 6'h20, 8'h01 << i);
			wr(6'h20, 8'hFF);
			run(8'h0A);
			rchk("flag_clear", 6'h20, ~(8'h01 << i));
		end
		run(8'h0D);
		chk("irq_on", 16'h0001, {15'h0000, irq_enable});
		run(8'h0E);
		chk("irq_off", 16'h0000, {15'h0000, irq_enable});
	endtask
	task automatic t_bits_moves;
		wr(6'h05, 8'h08);
		wr(6'h06, 8'h00);
		wr(6'h20, 8'h00);
		opnd(8'h05, 8'h05, 8'h03);
		run(8'h0B);
		rchk("bit_to_t", 6'h20, 8'h40);
		opnd(8'h06, 8'h06, 8'h06);
		run(8'h0C);
		rchk("t_to_bit", 6'h06, 8'h40);
		wr(6'h20, 8'h5A);
		wr(6'h10, 8'h11);
		wr(`ADDR_IMM, 8'hC3);
		opnd(8'h11, 8'h00, 8'h00);
		run(8'h11);
		rchk("load_imm", 6'h11, 8'hC3);
		opnd(8'h12, 8'h11, 8'h00);
		run(8'h0F);
		rchk("reg_copy", 6'h12, 8'hC3);
		opnd(8'h14, 8'h10, 8'h00);
		run(8'h10);
		rchk("pair_low", 6'h14, 8'h11);
		rchk("pair_high", 6'h15, 8'hC3);
		rchk("move_flags", 6'h20, 8'h5A);
	endtask
	task automatic t_memory;
		wr(6'h01, 8'hA7);
		pair(6'h1A, 16'h0010);
		opnd(8'h00, 8'h01, 8'h20);
		run(8'h13);
		rchk("x_store_inc", 6'h1A, 8'h11);
		opnd(8'h02, 8'h01, 8'h40);
		run(8'h12);
		rchk("x_predec", 6'h1A, 8'h10);
		rchk("load_predec", 6'h02, 8'hA7);
		opnd(8'h00, 8'h05, 8'h40);
		run(8'h13);
		rchk("x_store_predec", 6'h1A, 8'h0F);
		opnd(8'h0A, 8'h05, 8'h00);
		run(8'h12);
		rchk("load_plain", 6'h0A, 8'h08);
		pair(6'h1C, 16'h000E);
		wr(`ADDR_IMM, 8'h02);
		opnd(8'h03, 8'h01, 8'h68);
		run(8'h12);
		rchk("load_disp", 6'h03, 8'hA7);
		rchk("y_kept", 6'h1C, 8'h0E);
		pair(`ADDR_KLO, 16'h00FF);
		run(8'h15);
		pair(6'h1E, 16'h00FF);
		opnd(8'h04, 8'h01, 8'h30);
		run(8'h12);
		rchk("load_postinc", 6'h04, 8'hA7);
		rchk("z_low", 6'h1E, 8'h00);
		rchk("z_high", 6'h1F, 8'h01);
		pair(`ADDR_KLO, 16'h0010);
		opnd(8'h08, 8'h01, 8'h00);
		run(8'h14);
		rchk("load_direct", 6'h08, 8'hA7);
		pair(`ADDR_SPLO, 16'h0040);
		run(8'h17);
		rchk("sp_push", `ADDR_SPLO, 8'h3F);
		opnd(8'h07, 8'h01, 8'h00);
		run(8'h18);
		rchk("pop_value", 6'h07, 8'hA7);
		rchk("sp_pop", `ADDR_SPLO, 8'h40);
		pair(6'h1E, 16'h0123);
		opnd(8'h09, 8'h01, 8'h00);
		run(8'h16);
		rchk("prog_default", 6'h00, 8'h1E);
		wr(`ADDR_MODE, 8'h20);
		run(8'h16);
		rchk("prog_named", 6'h09, 8'h1E);
		rchk("z_prog_inc", 6'h1E, 8'h24);
	endtask
	task automatic t_io_ctrl;
		wr(`ADDR_IMM, 8'h1F);
		wr(`ADDR_MODE, 8'h05);
		run(8'h01);
		chk("io_set", {6'h00, 1'b1, 1'b0, 3'd5, 5'h1F}, {6'h00, io_seen});
		wr(`ADDR_IMM, 8'h00);
		wr(`ADDR_MODE, 8'h00);
		run(8'h02);
		chk("io_clear", {6'h00, 1'b0, 1'b1, 3'd0, 5'h00}, {6'h00, io_seen});
		wr(`ADDR_IMM, 8'h20);
		run(8'h01);
		chk("io_count", 16'h0002, io_cnt[15:0]);
		rchk("io_refused", `ADDR_STAT, 8'h02);
		run(8'h00);
		rchk("nop_accepted", `ADDR_STAT, 8'h00);
		wr(`ADDR_MODE, 8'h60);
		run(8'h12);
		rchk("disp_x_refused", `ADDR_STAT, 8'h02);
		run(8'h00);
		run(8'h1C);
		rchk("op_refused", `ADDR_STAT, 8'h02);
		rchk("unmapped", 6'h3F, 8'h00);
		wr(6'h20, 8'h35);
		run(8'h19);
		run(8'h1A);
		run(8'h1B);
		chk("ctl_pulses", 16'h0003, ctl_cnt[15:0]);
		rchk("ctl_flags", 6'h20, 8'h35);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		t_shift;
		t_flags;
		t_bits_moves;
		t_memory;
		t_io_ctrl;
		final_report;
	end
endmodule // cpu_bit_transfer_instr_exec_test
`default_nettype wire
